/* File: hdl/timer_pkg.sv */
// Shared constants for the down timer, PWM, buzzer and infrared block
package timer_pkg;

	// Register offsets on the plain register port
	localparam logic [2:0] OFF_COUNT_LOW    = 3'h0;
	localparam logic [2:0] OFF_CONTROL_ONE  = 3'h1;
	localparam logic [2:0] OFF_CONTROL_TWO  = 3'h2;
	localparam logic [2:0] OFF_DUTY_LOW     = 3'h3;
	localparam logic [2:0] OFF_PRESCALE     = 3'h4;
	localparam logic [2:0] OFF_BUZZER       = 3'h5;
	localparam logic [2:0] OFF_INFRARED     = 3'h6;
	localparam logic [2:0] OFF_SHARED_HIGH  = 3'h7;

	// timer_control_one fields
	localparam int CR1_ENABLE_BIT   = 0;
	localparam int CR1_RELOAD_BIT   = 1;
	localparam int CR1_ONESHOT_BIT  = 2;
	localparam int CR1_PWM_AL_BIT   = 6;
	localparam int CR1_PWM_OE_BIT   = 7;

	// timer_control_two fields
	localparam int CR2_SEL_LSB      = 0;
	localparam int CR2_PS_DIS_BIT   = 3;
	localparam int CR2_EDGE_BIT     = 4;
	localparam int CR2_SRC_BIT      = 5;

	// buzzer_control fields
	localparam int BUZ_SEL_LSB      = 0;
	localparam int BUZ_EN_BIT       = 7;

	// infrared_control fields
	localparam int IR_EN_BIT        = 0;
	localparam int IR_FAST_BIT      = 1;
	localparam int IR_POL_BIT       = 2;

	// shared_high_bits fields
	localparam int HIGH_DUTY_LSB    = 0;
	localparam int HIGH_RELOAD_LSB  = 4;

	// Values after reset, and the free-running wrap value
	localparam logic [2:0] PS_SEL_RST   = 3'h7;
	localparam logic [3:0] BUZ_SEL_RST  = 4'hf;
	localparam logic [7:0] PRESCALE_RST = 8'hff;
	localparam logic [9:0] COUNT_RST    = 10'h000;
	localparam logic [9:0] COUNT_WRAP   = 10'h3ff;

	// Infrared carrier division of the 4 MHz source
	localparam logic [6:0] IR_DIV_57K   = 7'h40;
	localparam logic [6:0] IR_DIV_38K   = 7'h60;
	localparam logic [6:0] IR_HALF_57K  = IR_DIV_57K >> 1;
	localparam logic [6:0] IR_HALF_38K  = IR_DIV_38K >> 1;

endpackage

/* File: hdl/edge_sync.sv */
// Two-flop synchroniser with registered rise and fall pulses
`timescale 1ns/1ns
module edge_sync (
	input  wire logic clk_i,
	input  wire logic rst_n_i,
	input  wire logic pin_i,
	output logic      rise_o,
	output logic      fall_o
);

	typedef struct packed {
		logic meta;
		logic sync;
		logic last;
		logic rise;
		logic fall;
	} sync_s;

	sync_s st_q;
	sync_s st_d;

	always_comb
	begin
		st_d      = st_q;
		st_d.meta = pin_i;
		st_d.sync = st_q.meta;
		st_d.last = st_q.sync;
		// Edges judged on the second and third stages only
		st_d.rise = st_q.sync & ~st_q.last;
		st_d.fall = ~st_q.sync & st_q.last;
	end

	always_ff @(posedge clk_i or negedge rst_n_i)
	begin
		if (!rst_n_i)
			st_q <= '0;
		else
			st_q <= st_d;
	end

	assign rise_o = st_q.rise;
	assign fall_o = st_q.fall;

endmodule

/* File: hdl/ir_carrier.sv */
// Infrared carrier divider running from pulses of the 4 MHz source
`timescale 1ns/1ns
module ir_carrier
	import timer_pkg::*;
(
	input  wire logic clk_i,
	input  wire logic rst_n_i,
	input  wire logic tick_i,
	input  wire logic enable_i,
	input  wire logic fast_i,
	output logic      carrier_o
);

	typedef struct packed {
		logic [6:0] cnt;
		logic       level;
	} carrier_s;

	carrier_s   st_q;
	carrier_s   st_d;
	logic [6:0] half;

	assign half = fast_i ? IR_HALF_57K : IR_HALF_38K;

	always_comb
	begin
		st_d = st_q;
		if (!enable_i)
		begin
			// Restart from a known phase on every enable
			st_d.cnt   = 7'h00;
			st_d.level = 1'b0;
		end
		else if (tick_i)
		begin
			if (st_q.cnt >= half - 7'h01)
			begin
				st_d.cnt   = 7'h00;
				st_d.level = ~st_q.level;
			end
			else
				st_d.cnt = st_q.cnt + 7'h01;
		end
	end

	always_ff @(posedge clk_i or negedge rst_n_i)
	begin
		if (!rst_n_i)
			st_q <= '0;
		else
			st_q <= st_d;
	end

	assign carrier_o = st_q.level;

	AST_IR_HALF_BOUND: assert property (@(posedge clk_i) disable iff (!rst_n_i)
		enable_i && $stable(fast_i) |-> st_q.cnt < IR_HALF_38K)
		else $error("carrier divider ran past its half period");

	AST_IR_FAST_TOGGLE: assert property (@(posedge clk_i) disable iff (!rst_n_i)
		enable_i && fast_i && tick_i && st_q.cnt == IR_HALF_57K - 7'h01 && $past(enable_i)
		|=> st_q.level != $past(st_q.level))
		else $error("fast carrier did not toggle after 32 source edges");

endmodule

/* File: hdl/down_timer_pwm_buzzer_ir.sv */
// Ten-bit down timer with prescaler, PWM, buzzer and infrared carrier
// Contract
// - Reading the count register returns the counter's low eight bits.
// - Writing the count register loads counter and reload from data plus high bits.
// - Counter counts only while its enable bit is set.
// - Free-running without auto-reload wraps to 0x3ff on underflow.
// - Free-running with auto-reload loads the reload value on underflow.
// - One-shot mode counts once to zero and stops at underflow.
// - PWM active-low bit set inverts the PWM output level.
// - PWM output enable puts the waveform on the pin, else buzzer tone if enabled, else ordinary port data.
// - Prescaler rate code selects division by two to the code plus one.
// - Prescaler disable bit set removes the prescaler from the clock path.
// - External edge bit chooses falling edges when set, rising when clear.
// - Clock source bit selects external pin when set, instruction clock otherwise.
// - PWM period is the reload value plus one ticks; duty is ten bits from two registers.
// - Prescaler count register reads the live prescaler, read-only, resets to ones.
// - Buzzer codes 0 to 7 take prescaler taps dividing by 2 to 256.
// - Buzzer codes 8 to 15 take counter bits 0 to 7.
// - Buzzer enable bit gates the buzzer output; it resets clear.
// - Infrared enable bit gates carrier generation; it resets clear.
// - Carrier frequency bit selects 62.5 kHz when set, about 41.7 kHz when clear.
// - Carrier polarity bit picks pin data one or zero for carrier output.
// - Carrier derives from the 4 MHz source divided by 64 or 96.
`timescale 1ns/1ns
module down_timer_pwm_buzzer_ir
	import timer_pkg::*;
(
	input  wire logic       SYS_CLK_I,
	input  wire logic       RST_N_I,
	input  wire logic [2:0] REG_ADDR_I,
	input  wire logic [7:0] REG_WDATA_I,
	input  wire logic       REG_WR_I,
	input  wire logic       REG_RD_I,
	input  wire logic       EXT_CLK_I,
	input  wire logic       HF_CLK_I,
	input  wire logic       GPIO_DATA_I,
	input  wire logic       IR_DATA_I,
	output logic [7:0]      REG_RDATA_O,
	output logic            PIN_DATA_O,
	output logic            PIN_OWNED_O,
	output logic            IR_O,
	output logic            UNDERFLOW_O
);

	typedef struct packed {
		logic [7:0] rdata;
		logic       en;
		logic       reload_sel;
		logic       one_shot;
		logic       pwm_al;
		logic       pwm_oe;
		logic [2:0] ps_sel;
		logic       ps_dis;
		logic       edge_fall;
		logic       src_ext;
		logic [7:0] duty_low;
		logic [5:0] high;
		logic [7:0] reload_low;
		logic [9:0] count;
		logic       os_done;
		logic [7:0] ps_count;
		logic       buz_en;
		logic [3:0] buz_sel;
		logic       ir_en;
		logic       ir_fast;
		logic       ir_pol;
		logic       pin;
		logic       owned;
		logic       ir;
		logic       underflow;
	} state_s;

	state_s     st_q;
	state_s     st_d;

	logic       ext_rise;
	logic       ext_fall;
	logic       hf_rise;
	logic       carrier;
	logic       src_tick;
	logic [3:0] ps_shift;
	logic [7:0] ps_mask;
	logic       ps_tick;
	logic       timer_tick;
	logic       cnt_wr;
	logic [9:0] reload_val;
	logic [9:0] duty_val;
	logic       pwm_level;
	logic       tone;
	logic       ir_gate;

	edge_sync u_ext_sync (
		.clk_i   (SYS_CLK_I),
		.rst_n_i (RST_N_I),
		.pin_i   (EXT_CLK_I),
		.rise_o  (ext_rise),
		.fall_o  (ext_fall)
	);

	edge_sync u_hf_sync (
		.clk_i   (SYS_CLK_I),
		.rst_n_i (RST_N_I),
		.pin_i   (HF_CLK_I),
		.rise_o  (hf_rise),
		.fall_o  ()
	);

	ir_carrier u_carrier (
		.clk_i     (SYS_CLK_I),
		.rst_n_i   (RST_N_I),
		.tick_i    (hf_rise),
		.enable_i  (st_q.ir_en),
		.fast_i    (st_q.ir_fast),
		.carrier_o (carrier)
	);

	// Instruction clock is one tick per system clock
	assign src_tick = st_q.src_ext ? (st_q.edge_fall ? ext_fall : ext_rise) : 1'b1;

	// Rate code n wraps the low n+1 prescaler bits
	assign ps_shift   = {1'b0, st_q.ps_sel} + 4'h1;
	assign ps_mask    = ~(8'hff << ps_shift);
	assign ps_tick    = src_tick && ((st_q.ps_count & ps_mask) == 8'h00);
	assign timer_tick = st_q.ps_dis ? src_tick : ps_tick;

	assign cnt_wr     = REG_WR_I && (REG_ADDR_I == OFF_COUNT_LOW);
	assign reload_val = {st_q.high[HIGH_RELOAD_LSB +: 2], st_q.reload_low};
	assign duty_val   = {st_q.high[HIGH_DUTY_LSB +: 2], st_q.duty_low};

	// Down counter runs from the reload value, so a smaller count means later in the frame
	assign pwm_level  = (st_q.count < duty_val) ^ st_q.pwm_al;
	assign tone       = st_q.buz_sel[3] ? st_q.count[st_q.buz_sel[2:0]]
	                                    : st_q.ps_count[st_q.buz_sel[2:0]];
	assign ir_gate    = st_q.ir_pol ? ~IR_DATA_I : IR_DATA_I;

	always_comb
	begin
		st_d           = st_q;
		st_d.rdata     = 8'h00;
		st_d.underflow = 1'b0;

		if (REG_RD_I)
		begin
			if (REG_ADDR_I == OFF_COUNT_LOW)
				st_d.rdata = st_q.count[7:0];
			else if (REG_ADDR_I == OFF_CONTROL_ONE)
				st_d.rdata = {5'h00, st_q.one_shot, st_q.reload_sel, st_q.en};
			else if (REG_ADDR_I == OFF_CONTROL_TWO)
				st_d.rdata = {2'h0, st_q.src_ext, st_q.edge_fall, st_q.ps_dis, st_q.ps_sel};
			else if (REG_ADDR_I == OFF_PRESCALE)
				st_d.rdata = st_q.ps_count;
			else if (REG_ADDR_I == OFF_SHARED_HIGH)
				st_d.rdata = {2'h0, st_q.high};
			else
				st_d.rdata = 8'h00;
		end

		// Prescaler advances on source ticks only while it is in the path
		if (!st_q.ps_dis && src_tick)
			st_d.ps_count = st_q.ps_count - 8'h01;

		if (cnt_wr)
		begin
			st_d.reload_low = REG_WDATA_I;
			st_d.count      = {st_q.high[HIGH_RELOAD_LSB +: 2], REG_WDATA_I};
			st_d.os_done    = 1'b0;
		end
		else if (st_q.en && timer_tick && !(st_q.one_shot && st_q.os_done))
		begin
			if (st_q.count == 10'h000)
			begin
				st_d.underflow = 1'b1;
				if (st_q.one_shot)
					st_d.os_done = 1'b1;
				else if (st_q.reload_sel)
					st_d.count = reload_val;
				else
					st_d.count = COUNT_WRAP;
			end
			else
				st_d.count = st_q.count - 10'h001;
		end
		if (!st_q.one_shot)
			st_d.os_done = 1'b0;

		if (REG_WR_I)
		begin
			if (REG_ADDR_I == OFF_CONTROL_ONE)
			begin
				st_d.en         = REG_WDATA_I[CR1_ENABLE_BIT];
				st_d.reload_sel = REG_WDATA_I[CR1_RELOAD_BIT];
				st_d.one_shot   = REG_WDATA_I[CR1_ONESHOT_BIT];
				st_d.pwm_al     = REG_WDATA_I[CR1_PWM_AL_BIT];
				st_d.pwm_oe     = REG_WDATA_I[CR1_PWM_OE_BIT];
			end
			else if (REG_ADDR_I == OFF_CONTROL_TWO)
			begin
				// Rate changes are the firmware's to time while disabled
				st_d.ps_sel    = REG_WDATA_I[CR2_SEL_LSB +: 3];
				st_d.ps_dis    = REG_WDATA_I[CR2_PS_DIS_BIT];
				st_d.edge_fall = REG_WDATA_I[CR2_EDGE_BIT];
				st_d.src_ext   = REG_WDATA_I[CR2_SRC_BIT];
			end
			else if (REG_ADDR_I == OFF_DUTY_LOW)
				st_d.duty_low = REG_WDATA_I;
			else if (REG_ADDR_I == OFF_BUZZER)
			begin
				st_d.buz_en  = REG_WDATA_I[BUZ_EN_BIT];
				st_d.buz_sel = REG_WDATA_I[BUZ_SEL_LSB +: 4];
			end
			else if (REG_ADDR_I == OFF_INFRARED)
			begin
				st_d.ir_en   = REG_WDATA_I[IR_EN_BIT];
				st_d.ir_fast = REG_WDATA_I[IR_FAST_BIT];
				st_d.ir_pol  = REG_WDATA_I[IR_POL_BIT];
			end
			else if (REG_ADDR_I == OFF_SHARED_HIGH)
				st_d.high = REG_WDATA_I[5:0];
		end

		// PWM takes the pin over the buzzer when both are enabled
		if (st_q.pwm_oe)
			st_d.pin = pwm_level;
		else if (st_q.buz_en)
			st_d.pin = tone;
		else
			st_d.pin = GPIO_DATA_I;
		st_d.owned = st_q.pwm_oe | st_q.buz_en;
		st_d.ir    = st_q.ir_en & carrier & ir_gate;
	end

	always_ff @(posedge SYS_CLK_I or negedge RST_N_I)
	begin
		if (!RST_N_I)
		begin
			st_q          <= '0;
			st_q.ps_sel   <= PS_SEL_RST;
			st_q.ps_dis   <= 1'b1;
			st_q.edge_fall <= 1'b1;
			st_q.src_ext  <= 1'b1;
			st_q.count    <= COUNT_RST;
			st_q.ps_count <= PRESCALE_RST;
			st_q.buz_sel  <= BUZ_SEL_RST;
		end
		else
			st_q <= st_d;
	end

	assign REG_RDATA_O = st_q.rdata;
	assign PIN_DATA_O  = st_q.pin;
	assign PIN_OWNED_O = st_q.owned;
	assign IR_O        = st_q.ir;
	assign UNDERFLOW_O = st_q.underflow;

	default clocking cb @(posedge SYS_CLK_I);
	endclocking
	default disable iff (!RST_N_I);

	sequence seq_counting;
		st_q.en && timer_tick && !cnt_wr && !(st_q.one_shot && st_q.os_done);
	endsequence

	sequence seq_underflow_free;
		seq_counting ##0 (st_q.count == 10'h000) && !st_q.one_shot;
	endsequence

	sequence seq_pwm_frame;
		st_q.pwm_oe && !REG_WR_I;
	endsequence

	AST_READ_COUNT: assert property (
		REG_RD_I && REG_ADDR_I == OFF_COUNT_LOW |=> REG_RDATA_O == $past(st_q.count[7:0]))
		else $error("count read did not return the live count");

	AST_WRITE_COUNT: assert property (
		cnt_wr |=> st_q.count == {$past(st_q.high[5:4]), $past(REG_WDATA_I)})
		else $error("count write did not load from data and high bits");

	AST_HOLD_DISABLED: assert property (
		!st_q.en && !cnt_wr ##1 !st_q.en && !cnt_wr |=> $stable(st_q.count) [*1])
		else $error("disabled counter moved");

	AST_WRAP_FREE: assert property (
		seq_underflow_free ##0 !st_q.reload_sel |=> st_q.count == COUNT_WRAP && UNDERFLOW_O)
		else $error("free-running underflow did not wrap to all ones");

	AST_RELOAD_FREE: assert property (
		seq_underflow_free ##0 st_q.reload_sel |=> st_q.count == $past(reload_val))
		else $error("auto-reload underflow loaded the wrong value");

	AST_ONE_SHOT_STOP: assert property (
		st_q.one_shot && st_q.os_done && !cnt_wr ##1 st_q.one_shot && !cnt_wr
		|-> st_q.count == 10'h000 && !UNDERFLOW_O)
		else $error("one-shot counter kept running after underflow");

	AST_PWM_LEVEL: assert property (
		seq_pwm_frame |=> PIN_DATA_O == ($past(st_q.count < duty_val) ^ $past(st_q.pwm_al)))
		else $error("pwm level or polarity wrong on the pin");

	AST_GPIO_PASS: assert property (
		!st_q.pwm_oe && !st_q.buz_en |=> PIN_DATA_O == $past(GPIO_DATA_I) && !PIN_OWNED_O)
		else $error("pin not returned to port data");

	// A rate write in the tick cycle changes the next tick, so it is left out
	AST_PRESCALE_DIV2: assert property (
		(!st_q.src_ext && !st_q.ps_dis && st_q.ps_sel == 3'h0
		&& !(REG_WR_I && REG_ADDR_I == OFF_CONTROL_TWO)) ##0 seq_counting
		|=> !timer_tick)
		else $error("divide-by-two prescaler ticked on consecutive cycles");

	AST_PRESCALE_HOLD: assert property (
		st_q.ps_dis |=> $stable(st_q.ps_count))
		else $error("disabled prescaler kept counting");

	AST_EXT_EDGE: assert property (
		st_q.src_ext && st_q.ps_dis && st_q.en && !cnt_wr
		&& !(st_q.edge_fall ? ext_fall : ext_rise) |=> $stable(st_q.count))
		else $error("counter moved without the selected external edge");

	AST_INT_SOURCE: assert property (
		(!st_q.src_ext && st_q.ps_dis && st_q.count != 10'h000) ##0 seq_counting
		|=> st_q.count == $past(st_q.count) - 10'h001)
		else $error("instruction clock did not step the counter");

	AST_RDATA_IDLE: assert property (
		!REG_RD_I |=> REG_RDATA_O == 8'h00)
		else $error("read data stood past its one cycle");

	AST_READ_PRESCALE: assert property (
		REG_RD_I && REG_ADDR_I == OFF_PRESCALE |=> REG_RDATA_O == $past(st_q.ps_count))
		else $error("prescaler read returned a stale value");

	AST_BUZZER_TONE: assert property (
		st_q.buz_en && !st_q.pwm_oe |=> PIN_DATA_O == $past(tone) && PIN_OWNED_O)
		else $error("buzzer tap not on the pin");

	AST_IR_OFF: assert property (
		!st_q.ir_en |=> !IR_O)
		else $error("carrier present while infrared disabled");

	AST_IR_GATE: assert property (
		st_q.ir_en && carrier |=> IR_O == ($past(st_q.ir_pol) ? !$past(IR_DATA_I) : $past(IR_DATA_I)))
		else $error("carrier gated by the wrong pin data level");

endmodule

/* File: verification/down_timer_pwm_buzzer_ir_bench.sv */
// Self-checking bench for the down timer, PWM, buzzer and infrared block
`timescale 1ns/1ns
module down_timer_pwm_buzzer_ir_bench
	import timer_pkg::*;
;
	logic        clk;
	logic        rst_n;
	logic [2:0]  addr;
	logic [7:0]  wdata;
	logic        wr;
	logic        rd;
	logic        ext_clk;
	logic        hf_clk;
	logic        gpio;
	logic        ir_data;
	logic [7:0]  rdata;
	logic        pin_data;
	logic        pin_owned;
	logic        ir_o;
	logic        uf;
	logic [31:0] rnd;
	logic [9:0]  n;
	logic [9:0]  d;
	int          error_cnt;
	int          n_checks;
	int          gap;
	int          hi;
	int          tg;

	down_timer_pwm_buzzer_ir dut (
		.SYS_CLK_I  (clk),
		.RST_N_I    (rst_n),
		.REG_ADDR_I (addr),
		.REG_WDATA_I(wdata),
		.REG_WR_I   (wr),
		.REG_RD_I   (rd),
		.EXT_CLK_I  (ext_clk),
		.HF_CLK_I   (hf_clk),
		.GPIO_DATA_I(gpio),
		.IR_DATA_I  (ir_data),
		.REG_RDATA_O(rdata),
		.PIN_DATA_O (pin_data),
		.PIN_OWNED_O(pin_owned),
		.IR_O       (ir_o),
		.UNDERFLOW_O(uf)
	);

	initial
	begin
		clk = 1'b0;
		forever #20 clk = ~clk;
	end

	// Carrier source is free running and unrelated in phase
	initial
	begin
		hf_clk = 1'b0;
		#7;
		forever #125 hf_clk = ~hf_clk;
	end

	function automatic logic [31:0] next_rnd(input logic [31:0] s);
		return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
	endfunction

	function automatic int pwm_hi(input logic [9:0] nn, input logic [9:0] dd, input logic al);
		int act;
		act = (dd <= nn) ? int'(dd) : int'(nn) + 1;
		return al ? int'(nn) + 1 - act : act;
	endfunction

	task automatic close_out();
		if (error_cnt == 0 && n_checks > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask

	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
		n_checks++;
		if (got !== exp)
		begin
			error_cnt++;
			$display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask

	task automatic cyc(input int k);
		repeat (k) @(posedge clk);
	endtask

	task automatic wr_reg(input logic [2:0] a, input logic [7:0] v);
		@(posedge clk);
		addr <= a;
		wdata <= v;
		wr <= 1'b1;
		@(posedge clk);
		wr <= 1'b0;
	endtask

	task automatic rd_chk(input logic [2:0] a, input logic [7:0] exp);
		@(posedge clk);
		addr <= a;
		rd <= 1'b1;
		@(posedge clk);
		rd <= 1'b0;
		#1;
		chk(16'(rdata), 16'(exp));
	endtask

	// Gap between two underflow pulses, each of the two waits bounded by lim cycles
	task automatic uf_gap(input int lim, output int g);
		int i;
		i = 0;
		g = 0;
		do
		begin
			@(posedge clk);
			#1;
			i++;
		end while (uf !== 1'b1 && i < lim);
		if (uf !== 1'b1)
		begin
			error_cnt++;
			$display("[ERR] t=%0t got=%h exp=%h", $time, i, lim);
			close_out();
		end
		do
		begin
			@(posedge clk);
			#1;
			g++;
		end while (uf !== 1'b1 && g < lim);
		if (g >= lim)
		begin
			error_cnt++;
			$display("[ERR] t=%0t got=%h exp=%h", $time, g, lim);
			close_out();
		end
	endtask

	// High cycles and level changes of one output over k cycles
	task automatic win(input int k, input int sel, output int h, output int t);
		logic v;
		logic p;
		int   i;
		h = 0;
		t = 0;
		@(posedge clk);
		#1;
		p = (sel == 0) ? pin_data : ((sel == 1) ? ir_o : uf);
		for (i = 0; i < k; i++)
		begin
			@(posedge clk);
			#1;
			v = (sel == 0) ? pin_data : ((sel == 1) ? ir_o : uf);
			h += int'(v === 1'b1);
			t += int'(v !== p);
			p = v;
		end
	endtask

	initial
	begin
		rst_n = 1'b0;
		addr = 3'h0;
		wdata = 8'h00;
		wr = 1'b0;
		rd = 1'b0;
		ext_clk = 1'b0;
		gpio = 1'b0;
		ir_data = 1'b1;
		rnd = 32'h41bdd5bb;
		error_cnt = 0;
		n_checks = 0;
		repeat (20) @(posedge clk);
		rst_n <= 1'b1;
		rd_chk(OFF_PRESCALE, PRESCALE_RST);
		wr_reg(OFF_PRESCALE, 8'h00);
		rd_chk(OFF_PRESCALE, PRESCALE_RST);
		rd_chk(OFF_CONTROL_ONE, 8'h00);
		rd_chk(OFF_CONTROL_TWO, 8'h3f);
		rd_chk(OFF_COUNT_LOW, 8'h00);
		chk(16'(pin_owned), 16'h0);
		chk(16'(ir_o), 16'h0);
		wr_reg(OFF_CONTROL_TWO, 8'h08);
		wr_reg(OFF_SHARED_HIGH, 8'h10);
		rd_chk(OFF_SHARED_HIGH, 8'h10);
		wr_reg(OFF_COUNT_LOW, 8'ha5);
		cyc(10);
		rd_chk(OFF_COUNT_LOW, 8'ha5);
		wr_reg(OFF_CONTROL_ONE, 8'hc6);
		rd_chk(OFF_CONTROL_ONE, 8'h06);
		wr_reg(OFF_CONTROL_ONE, 8'h01);
		uf_gap(2000, gap);
		chk(16'(gap), 16'd1024);
		rnd = next_rnd(rnd);
		n = {2'b01, rnd[7:0]};
		wr_reg(OFF_COUNT_LOW, n[7:0]);
		wr_reg(OFF_CONTROL_ONE, 8'h03);
		uf_gap(2000, gap);
		chk(16'(gap), 16'(n) + 16'h1);
		for (int k = 0; k < 2; k++)
		begin
			wr_reg(OFF_CONTROL_ONE, 8'h00);
			wr_reg(OFF_SHARED_HIGH, 8'h00);
			wr_reg(OFF_COUNT_LOW, 8'h08);
			wr_reg(OFF_CONTROL_ONE, (k == 1) ? 8'h07 : 8'h05);
			win(60, 2, hi, tg);
			chk(16'(hi), 16'h1);
			rd_chk(OFF_COUNT_LOW, 8'h00);
		end
		for (int r = 0; r < 8; r++)
		begin
			wr_reg(OFF_CONTROL_ONE, 8'h00);
			wr_reg(OFF_CONTROL_TWO, 8'h08 | 8'(r));
			wr_reg(OFF_CONTROL_TWO, 8'(r));
			wr_reg(OFF_COUNT_LOW, 8'h03);
			wr_reg(OFF_CONTROL_ONE, 8'h03);
			uf_gap(3000, gap);
			chk(16'(gap), 16'(4 << (r + 1)));
		end
		// Odd toggle count: rising and falling edges differ by one
		for (int m = 0; m < 2; m++)
		begin
			wr_reg(OFF_CONTROL_ONE, 8'h00);
			wr_reg(OFF_CONTROL_TWO, (m == 1) ? 8'h38 : 8'h28);
			wr_reg(OFF_COUNT_LOW, 8'h40);
			wr_reg(OFF_CONTROL_ONE, 8'h01);
			repeat (7)
			begin
				cyc(6);
				ext_clk <= ~ext_clk;
			end
			cyc(8);
			wr_reg(OFF_CONTROL_ONE, 8'h00);
			rd_chk(OFF_COUNT_LOW, (m == 1) ? 8'h3d : 8'h3c);
			@(posedge clk);
			ext_clk <= 1'b0;
			cyc(6);
		end
		wr_reg(OFF_CONTROL_TWO, 8'h08);
		for (int k = 0; k < 4; k++)
		begin
			rnd = next_rnd(rnd);
			n = {2'b01, rnd[7:0]};
			d = {1'b0, rnd[16], rnd[15:8]};
			wr_reg(OFF_SHARED_HIGH, {2'b00, n[9:8], 2'b00, d[9:8]});
			wr_reg(OFF_COUNT_LOW, n[7:0]);
			wr_reg(OFF_DUTY_LOW, d[7:0]);
			wr_reg(OFF_CONTROL_ONE, {1'b1, rnd[20], 6'h03});
			cyc(4);
			win(int'(n) + 1, 0, hi, tg);
			chk(16'(hi), 16'(pwm_hi(n, d, rnd[20])));
			chk(16'(pin_owned), 16'h1);
		end
		// Free running wrap keeps every counter bit periodic
		wr_reg(OFF_CONTROL_ONE, 8'h01);
		for (int c = 0; c < 16; c++)
		begin
			wr_reg(OFF_CONTROL_TWO, (c < 8) ? 8'h00 : 8'h08);
			wr_reg(OFF_BUZZER, 8'h80 | 8'(c));
			cyc(4);
			win(256, 0, hi, tg);
			chk(16'(tg), 16'(256 >> (c % 8)));
			chk(16'(pin_owned), 16'h1);
		end
		wr_reg(OFF_BUZZER, 8'h0f);
		for (int k = 0; k < 6; k++)
		begin
			rnd = next_rnd(rnd);
			@(posedge clk);
			gpio <= rnd[3];
			cyc(2);
			#1;
			chk(16'(pin_data), 16'(rnd[3]));
			chk(16'(pin_owned), 16'h0);
		end
		wr_reg(OFF_INFRARED, 8'h03);
		cyc(20);
		win(2400, 1, hi, tg);
		chk(16'(tg >= 11 && tg <= 13), 16'h1);
		wr_reg(OFF_INFRARED, 8'h00);
		wr_reg(OFF_INFRARED, 8'h01);
		cyc(20);
		win(2400, 1, hi, tg);
		chk(16'(tg >= 7 && tg <= 9), 16'h1);
		wr_reg(OFF_INFRARED, 8'h05);
		win(1200, 1, hi, tg);
		chk(16'(hi), 16'h0);
		@(posedge clk);
		ir_data <= 1'b0;
		cyc(20);
		win(2400, 1, hi, tg);
		chk(16'(tg >= 7 && tg <= 9), 16'h1);
		wr_reg(OFF_INFRARED, 8'h04);
		win(1200, 1, hi, tg);
		chk(16'(hi), 16'h0);
		close_out();
	end
endmodule
